// >>> logic/ecp_pkg.sv
// Shared constants and types of the experiment control port.
package ecp_pkg;

  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS    = 100;
  localparam int unsigned GPS_BAUD         = 115_200;
  localparam int unsigned GPS_BIT_CYC      = (CLK_HZ + GPS_BAUD / 2) / GPS_BAUD;
  localparam int unsigned GPS_HALF_CYC     = GPS_BIT_CYC / 2;
  localparam int unsigned TRIG_MIN_NS      = 100;
  localparam int unsigned TRIG_MIN_CYC     = (TRIG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TRIG_PULSE_NS    = 10;
  localparam int unsigned TRIG_PULSE_CYC   = 1;
  localparam int unsigned MARKER_ERR_NS    = 100;
  localparam int unsigned SYNC_LAT_CYC     = 3;
  localparam int unsigned NUM_MARKERS      = 4;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_TRIG   = 8'h08;
  localparam logic [7:0] ADR_TOD    = 8'h0C;
  localparam logic [7:0] ADR_DATE   = 8'h10;
  localparam logic [7:0] ADR_SUBSEC = 8'h14;

  // Control register fields.
  localparam int unsigned CTRL_SW_START = 0;
  localparam int unsigned CTRL_SW_STOP  = 1;
  localparam int unsigned CTRL_HW_START = 2;
  localparam int unsigned CTRL_HW_STOP  = 3;
  localparam int unsigned CTRL_EDGE_LSB = 4;
  localparam int unsigned CTRL_EXT_REF  = 8;
  localparam int unsigned CTRL_WR_MODE  = 9;
  localparam int unsigned CTRL_TRIG_EN  = 10;
  localparam logic [10:0] CTRL_RESET    = 11'h000;
  localparam logic [23:0] TRIG_RESET    = 24'h000063;

  // ------------------------------------------------------------
  // Record stream
  // ------------------------------------------------------------
  localparam int unsigned REC_W   = 32;
  localparam int unsigned STAMP_W = 29;

  typedef enum logic [1:0] {ECP_ZDA_IDLE, ECP_ZDA_HDR, ECP_ZDA_FIELD} ecp_zda_e;

endpackage

// >>> logic/ecp_serial_if.sv
// Byte hand-off from the serial time-code receiver to the decoder.
`timescale 1ns/1ns
interface ecp_serial_if;
  logic       valid;
  logic [7:0] data;
  logic       frame_err;
  modport rx   (output valid, output data, output frame_err);
  modport sink (input valid, input data, input frame_err);
endinterface

// >>> logic/ecp_uart_rx.sv
// Asynchronous serial receiver for the satellite time code line.
`timescale 1ns/1ns
module ecp_uart_rx
  import ecp_pkg::*;
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Serial line
  input  wire logic i_rx,
  // Received bytes
  ecp_serial_if.rx  rx
);

  logic [1:0]  sync;
  logic        busy;
  logic [7:0]  cnt;
  logic [3:0]  bit_idx;
  logic [7:0]  shift;
  wire         line   = sync[1];
  wire         tick   = busy && (cnt == 8'h00);

  // ------------------------------------------------------------
  // Line sampling, 8N1, mid-bit sampling
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst)
      sync <= 2'h3;
    else
      sync <= {sync[0], i_rx};

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      busy      <= 1'b0;
      cnt       <= 8'h00;
      bit_idx   <= 4'h0;
      shift     <= 8'h00;
      rx.valid  <= 1'b0;
      rx.data   <= 8'h00;
      rx.frame_err <= 1'b0;
    end
    else
    begin
      rx.valid     <= 1'b0;
      rx.frame_err <= 1'b0;
      if (!busy)
      begin
        if (!line)
        begin
          busy    <= 1'b1;
          cnt     <= 8'(GPS_HALF_CYC);
          bit_idx <= 4'h0;
        end
      end
      else if (!tick)
        cnt <= cnt - 8'h01;
      else
      begin
        cnt     <= 8'(GPS_BIT_CYC - 1);
        bit_idx <= bit_idx + 4'h1;
        if (bit_idx == 4'h0 && line)
          busy <= 1'b0;          // A glitch, not a start bit.
        else if (bit_idx == 4'h9)
        begin
          busy         <= 1'b0;
          rx.valid     <= line;
          rx.frame_err <= !line;
          rx.data      <= shift;
        end
        else if (bit_idx != 4'h0)
          shift <= {line, shift[7:1]};
      end
    end
  end

endmodule

// >>> logic/ecp_ctrl_port.sv
// Experiment control port: markers, start/stop, trigger, clock reference and time code.
//
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module ecp_ctrl_port
  import ecp_pkg::*;
(
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  // Wishbone slave
  input  wire logic               i_wb_cyc,
  input  wire logic               i_wb_stb,
  input  wire logic               i_wb_we,
  input  wire logic [7:0]         i_wb_adr,
  input  wire logic [3:0]         i_wb_sel,
  input  wire logic [31:0]        i_wb_dat,
  output      logic [31:0]        o_wb_dat,
  output      logic               o_wb_ack,
  // Experiment pins
  input  wire logic [3:0]         i_marker,
  input  wire logic               i_hw_start_input,
  input  wire logic               i_hw_stop_input,
  input  wire logic               i_gps_rx,
  input  wire logic               i_pulse_per_second_input,
  output      logic               o_measurement_active_out,
  output      logic               o_trigger_pulse_output,
  // Clock reference control
  input  wire logic               i_pll_locked,
  output      logic               o_pll_ref_ext,
  output      logic               o_ref_out_wr_mode,
  // Photon records in
  input  wire logic               i_ph_valid,
  input  wire logic [REC_W-2:0]   i_ph_data,
  output      logic               o_ph_ready,
  output      logic               o_ph_drop,
  // Time-tagged record stream out
  output      logic               o_rec_valid,
  output      logic [REC_W-1:0]   o_rec_data,
  input  wire logic               i_rec_ready
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[i*8 +: 8] = wr[i*8 +: 8];
    return r;
  endfunction
  function automatic logic [11:0] add_digit(input logic [11:0] acc, input logic [7:0] ch);
    return 12'(acc * 12'h00A + 12'(ch - 8'h30));
  endfunction

  // ------------------------------------------------------------
  // Input synchronisers and edge detection
  // ------------------------------------------------------------
  logic [6:0] sync1;
  logic [6:0] sync2;
  logic [6:0] sync3;
  wire  [6:0] raw_in = {i_pulse_per_second_input, i_hw_stop_input, i_hw_start_input, i_marker};
  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst)
      {sync3, sync2, sync1} <= 21'h000000;
    else
      {sync3, sync2, sync1} <= {sync2, sync1, raw_in};

  logic [10:0] ctrl;
  wire  [6:0]  rise      = sync2 & ~sync3;
  wire  [6:0]  fall      = ~sync2 & sync3;
  wire  [3:0]  edge_sel  = ctrl[CTRL_EDGE_LSB +: 4];
  wire  [3:0]  mk_event  = (edge_sel & fall[3:0]) | (~edge_sel & rise[3:0]);
  wire         hw_start  = rise[4] && ctrl[CTRL_HW_START];
  wire         hw_stop   = rise[5] && ctrl[CTRL_HW_STOP];
  wire         pps_edge  = rise[6];

  // ------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------
  logic [23:0] trig_period;
  wire         wb_req    = i_wb_cyc && i_wb_stb && !o_wb_ack;
  wire         wb_wr     = wb_req && i_wb_we;
  wire         wr_ctrl   = wb_wr && (i_wb_adr == ADR_CTRL);
  wire         wr_trig   = wb_wr && (i_wb_adr == ADR_TRIG);
  wire [31:0]  ctrl_new  = merge({21'h0, ctrl}, i_wb_dat, i_wb_sel);
  wire         sw_start  = wr_ctrl && ctrl_new[CTRL_SW_START];
  wire         sw_stop   = wr_ctrl && ctrl_new[CTRL_SW_STOP];

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl        <= CTRL_RESET;
      trig_period <= TRIG_RESET;
      o_wb_ack    <= 1'b0;
    end
    else
    begin
      o_wb_ack <= wb_req;
      if (wr_ctrl)
        ctrl <= {ctrl_new[10:2], 2'b00};
      if (wr_trig)
        trig_period <= 24'(merge({8'h00, trig_period}, i_wb_dat, i_wb_sel));
    end
  end

  // ------------------------------------------------------------
  // Measurement state
  // ------------------------------------------------------------
  logic meas;

  // A stop seen in the same cycle as a start wins, so a glitch never leaves it running.
  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst)
      meas <= 1'b0;
    else if (hw_stop || sw_stop)
      meas <= 1'b0;
    else if (hw_start || sw_start)
      meas <= 1'b1;

  assign o_measurement_active_out = meas;

  // ------------------------------------------------------------
  // Trigger generator
  // ------------------------------------------------------------
  // Period register holds cycles minus one, so 0 gives 0.1 us and 24'hFFFFFF 1.678 s.
  // The pulse is one clock long for any period above 0 (0 holds it high); at this clock rate that is the shortest a pulse can be.
  logic [23:0] trig_cnt;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      {trig_cnt, o_trigger_pulse_output} <= 25'h0000000;
    else if (!ctrl[CTRL_TRIG_EN])
      {trig_cnt, o_trigger_pulse_output} <= {trig_period, 1'b0};
    else
    begin
      o_trigger_pulse_output <= (trig_cnt == 24'h000000);
      trig_cnt <= (trig_cnt == 24'h000000) ? trig_period : trig_cnt - 24'h000001;
    end
  end

  // ------------------------------------------------------------
  // Clock reference selection
  // ------------------------------------------------------------
  // The analog PLL and reference mux act on these levels.
  assign o_pll_ref_ext     = ctrl[CTRL_EXT_REF];
  assign o_ref_out_wr_mode = ctrl[CTRL_WR_MODE];

  // ------------------------------------------------------------
  // Time code decoding
  // ------------------------------------------------------------
  ecp_serial_if ser ();

  ecp_uart_rx u_rx
  (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_rx  (i_gps_rx),
    .rx    (ser)
  );

  ecp_zda_e    zst;
  logic [2:0]  fld;
  logic [3:0]  pos;
  logic [23:0] hdr;
  logic [11:0] acc;
  logic [4:0]  p_hour;
  logic [5:0]  p_min;
  logic [5:0]  p_sec;
  logic [4:0]  p_day;
  logic [3:0]  p_mon;
  logic [11:0] p_year;
  logic        p_valid;
  wire  [7:0]  ch       = ser.data;
  wire         is_digit = (ch >= 8'h30) && (ch <= 8'h39);
  wire         is_comma = (ch == 8'h2C);
  wire         is_end   = (ch == 8'h2A) || (ch == 8'h0D);
  wire [11:0]  acc_next = add_digit(acc, ch);

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      zst     <= ECP_ZDA_IDLE;
      p_valid <= 1'b0;
      {fld, pos, hdr, acc} <= 43'h00000000000;
      {p_hour, p_min, p_sec, p_day, p_mon, p_year} <= 38'h0000000000;
    end
    else
    begin
      if (pps_edge)
        p_valid <= 1'b0;
      if (ser.frame_err)
        zst <= ECP_ZDA_IDLE;
      else if (ser.valid)
      begin
        if (ch == 8'h24)
        begin
          zst <= ECP_ZDA_HDR;
          hdr <= 24'h000000;
        end
        else
        begin
          unique case (zst)
            ECP_ZDA_IDLE : ;
            ECP_ZDA_HDR :
              if (is_comma)
              begin
                zst <= (hdr == 24'h5A4441) ? ECP_ZDA_FIELD : ECP_ZDA_IDLE;
                fld <= 3'h1;
                pos <= 4'h0;
                acc <= 12'h000;
              end
              else
                hdr <= {hdr[15:0], ch};
            ECP_ZDA_FIELD :
              if (is_comma || is_end)
              begin
                unique case (fld)
                  3'h2    : p_day  <= 5'(acc);
                  3'h3    : p_mon  <= 4'(acc);
                  3'h4    : p_year <= acc;
                  default : ;
                endcase
                fld <= fld + 3'h1;
                pos <= 4'h0;
                acc <= 12'h000;
                if (is_end)
                begin
                  zst     <= ECP_ZDA_IDLE;
                  p_valid <= (fld >= 3'h4);
                end
              end
              else if (is_digit)
              begin
                pos <= pos + 4'h1;
                if (fld == 3'h1)
                begin
                  acc <= (pos[0]) ? 12'h000 : 12'(ch - 8'h30);
                  if (pos == 4'h1)
                    p_hour <= 5'(acc_next);
                  if (pos == 4'h3)
                    p_min <= 6'(acc_next);
                  if (pos == 4'h5)
                    p_sec <= 6'(acc_next);
                end
                else
                  acc <= acc_next;
              end
          endcase
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Time base
  // ------------------------------------------------------------
  // The sentence names the second that the next PPS edge opens.
  logic [31:0] tod;
  logic [31:0] date;
  logic [31:0] subsec;
  logic        synced;
  logic [31:0] meas_time;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      {tod, date, subsec, meas_time} <= 128'h0;
      synced                         <= 1'b0;
    end
    else
    begin
      meas_time <= (sw_start || hw_start) && !meas ? 32'h00000000 : meas_time + 32'h00000001;
      subsec    <= pps_edge ? 32'(SYNC_LAT_CYC) : subsec + 32'h00000001;
      if (pps_edge && p_valid)
      begin
        tod    <= {15'h0000, p_hour, p_min, p_sec};
        date   <= {11'h000, p_year, p_day, p_mon};
        synced <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Marker capture and record arbitration
  // ------------------------------------------------------------
  logic [3:0]         mk_pend;
  logic [STAMP_W-1:0] mk_stamp [NUM_MARKERS];
  wire  [1:0]         mk_pick  = mk_pend[0] ? 2'h0 : mk_pend[1] ? 2'h1 : mk_pend[2] ? 2'h2 : 2'h3;
  wire                out_free = !o_rec_valid || i_rec_ready;
  wire                mk_take  = out_free && (mk_pend != 4'h0);
  wire  [3:0]         mk_clr   = mk_take ? (4'h1 << mk_pick) : 4'h0;
  // The stamp is backed off by the synchroniser delay, which leaves it one to two cycles before the marker edge.
  wire  [STAMP_W-1:0] now      = STAMP_W'(meas_time - 32'(SYNC_LAT_CYC));

  assign o_ph_ready = out_free && (mk_pend == 4'h0);
  assign o_ph_drop  = i_ph_valid && !o_ph_ready;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      {mk_pend, o_rec_valid, o_rec_data} <= 37'h0000000000;
      for (int i = 0; i < NUM_MARKERS; i++)
        mk_stamp[i] <= '0;
    end
    else
    begin
      // A new edge in the cycle its pending bit is taken still sets it again.
      mk_pend <= (mk_pend & ~mk_clr) | (mk_event & {4{meas}});
      for (int i = 0; i < NUM_MARKERS; i++)
        if (mk_event[i] && meas)
          mk_stamp[i] <= now;
      if (mk_take)
      begin
        o_rec_valid <= 1'b1;
        o_rec_data  <= {1'b1, mk_pick, mk_stamp[mk_pick]};
      end
      else if (o_ph_ready && i_ph_valid)
      begin
        o_rec_valid <= 1'b1;
        o_rec_data  <= {1'b0, i_ph_data};
      end
      else if (i_rec_ready)
        o_rec_valid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Register read back
  // ------------------------------------------------------------
  wire [31:0] status = {28'h0000000, synced, p_valid, i_pll_locked, meas};
  wire [31:0] rd_mux = (i_wb_adr == ADR_CTRL)   ? {21'h000000, ctrl} :
                       (i_wb_adr == ADR_STATUS) ? status :
                       (i_wb_adr == ADR_TRIG)   ? {8'h00, trig_period} :
                       (i_wb_adr == ADR_TOD)    ? tod :
                       (i_wb_adr == ADR_DATE)   ? date :
                       (i_wb_adr == ADR_SUBSEC) ? subsec : 32'h00000000;

  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst)
      o_wb_dat <= 32'h00000000;
    else if (wb_req)
      o_wb_dat <= rd_mux;

endmodule

// >>> testbench/ecp_ctrl_port_sva.sv
// Checker of the experiment control port pin behaviour.
`timescale 1ns/1ns
module ecp_ctrl_port_sva
  import ecp_pkg::*;
(
  input wire logic        i_clk, i_rst, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack,
  input wire logic [7:0]  i_wb_adr,
  input wire logic [31:0] i_wb_dat, o_rec_data,
  input wire logic [3:0]  i_marker, i_wb_sel,
  input wire logic        i_hw_start_input, i_hw_stop_input, o_measurement_active_out,
  input wire logic        o_trigger_pulse_output, o_pll_ref_ext, o_ref_out_wr_mode,
  input wire logic        i_ph_valid, o_ph_ready, o_ph_drop, o_rec_valid, i_rec_ready
);
  wire         req     = i_wb_cyc & i_wb_stb & !o_wb_ack;
  wire         wr_ctrl = req & i_wb_we & (i_wb_adr == ADR_CTRL);
  wire         wr_trig = req & i_wb_we & (i_wb_adr == ADR_TRIG);
  wire         meas    = o_measurement_active_out;
  wire         trig    = o_trigger_pulse_output;
  wire [1:0]   ref_sel = {o_ref_out_wr_mode, o_pll_ref_ext};
  wire [1:0]   ref_req = i_wb_sel[1] ? i_wb_dat[9:8] : ref_sel;
  logic [7:0]  ctl;
  logic [23:0] per;
  logic [24:0] gap;
  logic        seen;
  // Shadows of what software asked for; a write to the control or trigger register clears the period history.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctl  <= 8'h00;
      per  <= TRIG_RESET;
      gap  <= 25'h0000000;
      seen <= 1'b0;
    end
    else
    begin
      if (wr_ctrl && i_wb_sel[0]) ctl <= i_wb_dat[7:0];
      for (int i = 0; i < 3; i++)
        if (wr_trig && i_wb_sel[i]) per[i*8 +: 8] <= i_wb_dat[i*8 +: 8];
      gap  <= trig ? 25'h0000001 : gap + 25'h0000001;
      seen <= !(wr_ctrl | wr_trig) & (seen | trig);
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_ack;
    req |=> o_wb_ack ##1 !o_wb_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse after request");
  property p_ref_sel;
    wr_ctrl |=> ref_sel == $past(ref_req);
  endproperty
  a_ref_sel: assert property (p_ref_sel) else $error("reference select pins wrong");
  property p_hw_start;
    ctl[2] && !meas && !i_hw_stop_input && $rose(i_hw_start_input) |-> ##[2:3] meas;
  endproperty
  a_hw_start: assert property (p_hw_start) else $error("start pin did not start");
  property p_hw_stop;
    ctl[3] && meas && $rose(i_hw_stop_input) |-> ##[2:3] !meas;
  endproperty
  a_hw_stop: assert property (p_hw_stop) else $error("stop pin did not stop");
  property p_hw_ignored;
    !ctl[3] && meas && !wr_ctrl && $rose(i_hw_stop_input) |=> meas [*4];
  endproperty
  a_hw_ignored: assert property (p_hw_ignored) else $error("disabled stop pin acted");
  property p_trig_short;
    trig && per != 24'h000000 |=> !trig;
  endproperty
  a_trig_short: assert property (p_trig_short) else $error("trigger pulse too long");
  property p_trig_period;
    trig && seen |-> gap == {1'b0, per} + 25'h0000001;
  endproperty
  a_trig_period: assert property (p_trig_period) else $error("trigger period wrong");
  property p_rec_hold;
    o_rec_valid && !i_rec_ready |=> o_rec_valid && $stable(o_rec_data);
  endproperty
  a_rec_hold: assert property (p_rec_hold) else $error("record changed while stalled");
  property p_drop;
    i_ph_valid && !o_ph_ready |-> o_ph_drop;
  endproperty
  a_drop: assert property (p_drop) else $error("refused photon not flagged");
  property p_marker0;
    meas && !ctl[4] && $rose(i_marker[0]) |-> ##[3:5] (o_rec_valid && o_rec_data[31:29] == 3'b100);
  endproperty
  a_marker0: assert property (p_marker0) else $error("marker record missing");
  c_marker: cover property (o_rec_valid && o_rec_data[31] && i_rec_ready);
  c_drop: cover property (o_ph_drop);
  c_trig: cover property (trig && seen);
endmodule
bind ecp_ctrl_port ecp_ctrl_port_sva i_ecp_ctrl_port_sva
(
  .i_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .o_wb_ack, .i_wb_adr, .i_wb_dat, .o_rec_data, .i_marker, .i_wb_sel,
  .i_hw_start_input, .i_hw_stop_input, .o_measurement_active_out, .o_trigger_pulse_output, .o_pll_ref_ext,
  .o_ref_out_wr_mode, .i_ph_valid, .o_ph_ready, .o_ph_drop, .o_rec_valid, .i_rec_ready
);

// >>> testbench/ecp_lab_model.sv
// Lab-side model: marker, start, stop and PPS pins plus the serial time-code line.
`timescale 1ns/1ns
module ecp_lab_model
  import ecp_pkg::*;
(
  // Clock
  input  wire logic       i_clk,
  // Pins towards the port: markers, start, stop, PPS
  output      logic [6:0] o_pins,
  output      logic       o_rx
);
  initial
  begin
    o_pins = 7'h00;
    o_rx   = 1'b1;
  end
  // Both levels last two cycles, which keeps the marker rate far below a flood.
  task automatic pulse(input int idx);
    o_pins[idx] <= 1'b1;
    repeat (2) @(posedge i_clk);
    o_pins[idx] <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      o_rx <= f[i];
      repeat (GPS_BIT_CYC) @(posedge i_clk);
    end
  endtask
  task automatic send_str(input string s);
    for (int i = 0; i < s.len(); i++)
      send_byte(s[i]);
  endtask
endmodule

// >>> testbench/ecp_ctrl_port_tb.sv
// Self-checking bench of the experiment control port.
`timescale 1ns/1ns
module ecp_ctrl_port_tb
  import ecp_pkg::*;
;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_wb_cyc = 1'b0;
  logic        i_wb_stb = 1'b0;
  logic        i_wb_we = 1'b0;
  logic [7:0]  i_wb_adr = 8'h00;
  logic [31:0] i_wb_dat = 32'h00000000;
  logic        i_ph_valid = 1'b0;
  logic        i_rec_ready = 1'b0;
  logic        i_pll_locked = 1'b1;
  logic [3:0]  wb_sel = 4'hF;
  logic [30:0] ph_data = 31'h00000000;
  wire  [31:0] o_wb_dat, o_rec_data;
  wire         o_wb_ack, o_meas, o_trig, o_ref_ext, o_wr_mode, o_ph_ready, o_ph_drop, o_rec_valid, rx;
  wire  [6:0]  pins;
  wire  [3:0]  lv = {o_trig, o_wr_mode, o_ref_ext, o_meas};
  int          n_errors = 0;
  int          samples_checked = 0;
  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) ph_data <= ph_data + 31'h1;
  ecp_ctrl_port i_ecp_ctrl_port
  (
    .i_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel(wb_sel), .i_wb_dat, .o_wb_dat, .o_wb_ack,
    .i_marker(pins[3:0]), .i_hw_start_input(pins[4]), .i_hw_stop_input(pins[5]), .i_gps_rx(rx),
    .i_pulse_per_second_input(pins[6]), .o_measurement_active_out(o_meas), .o_trigger_pulse_output(o_trig),
    .i_pll_locked, .o_pll_ref_ext(o_ref_ext), .o_ref_out_wr_mode(o_wr_mode), .i_ph_valid, .i_ph_data(ph_data),
    .o_ph_ready, .o_ph_drop, .o_rec_valid, .o_rec_data, .i_rec_ready
  );
  ecp_lab_model i_ecp_lab_model
  (
    .i_clk, .o_pins(pins), .o_rx(rx)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Pin levels are looked at mid-cycle, where they have settled.
  task automatic pin(input int s, input logic e);
    @(negedge i_clk);
    chk({31'h0, lv[s]}, {31'h0, e});
    @(posedge i_clk);
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= we;
    i_wb_adr <= a;
    i_wb_dat <= d;
    @(negedge i_clk);
    while (o_wb_ack !== 1'b1 && n < 20)
    begin
      @(negedge i_clk);
      n++;
    end
    chk({31'h0, o_wb_ack}, 32'h1);
    @(posedge i_clk);
    q = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  task automatic t_regs();
    rd(ADR_CTRL, 32'h0, 32'hFFFFFFFF);
    rd(ADR_TRIG, 32'h63, 32'hFFFFFFFF);
    rd(ADR_STATUS, 32'h2, 32'h3);
    i_pll_locked <= 1'b0;
    rd(ADR_STATUS, 32'h0, 32'h2);
    i_pll_locked <= 1'b1;
    wr(8'h20, 32'hFFFFFFFF);
    rd(8'h20, 32'h0, 32'hFFFFFFFF);
    pin(2, 1'b0);
    wr(ADR_CTRL, 32'h300);
    pin(1, 1'b1);
    pin(2, 1'b1);
    wb_sel <= 4'h1;
    wr(ADR_CTRL, 32'h0);
    wb_sel <= 4'hF;
    pin(1, 1'b1);
    wr(ADR_CTRL, 32'h0);
    pin(2, 1'b0);
    $display("register test done");
  endtask
  task automatic t_meas();
    wr(ADR_CTRL, 32'h1);
    pin(0, 1'b1);
    rd(ADR_STATUS, 32'h1, 32'h1);
    wr(ADR_CTRL, 32'h2);
    pin(0, 1'b0);
    i_ecp_lab_model.pulse(4);
    pin(0, 1'b0);
    wr(ADR_CTRL, 32'hC);
    i_ecp_lab_model.pulse(4);
    pin(0, 1'b1);
    wr(ADR_CTRL, 32'h4);
    i_ecp_lab_model.pulse(5);
    pin(0, 1'b1);
    wr(ADR_CTRL, 32'hC);
    i_ecp_lab_model.pulse(5);
    pin(0, 1'b0);
    $display("start stop test done");
  endtask
  task automatic t_markers();
    int n;
    int m;
    wr(ADR_CTRL, 32'h21);
    for (int ch = 0; ch < 4; ch++)
    begin
      i_ecp_lab_model.pulse(ch);
      n = 0;
      @(negedge i_clk);
      while (o_rec_valid !== 1'b1 && n < 20)
      begin
        @(negedge i_clk);
        n++;
      end
      chk({29'h0, o_rec_data[31:29]}, {29'h0, 1'b1, ch[1:0]});
      @(posedge i_clk);
      i_rec_ready <= 1'b1;
      @(posedge i_clk);
      i_rec_ready <= 1'b0;
      pin(3, 1'b0);
      @(negedge i_clk);
      chk({31'h0, o_rec_valid}, 32'h0);
      @(posedge i_clk);
    end
    i_rec_ready <= 1'b1;
    i_ph_valid  <= 1'b1;
    n = 0;
    m = 0;
    fork
      i_ecp_lab_model.pulse(2);
      repeat (12)
      begin
        @(negedge i_clk);
        if (o_rec_valid === 1'b1 && o_rec_data[31] === 1'b1) n++;
        if (o_ph_drop === 1'b1) m++;
      end
    join
    chk(n, 1);
    chk(m > 0, 1);
    chk({30'h0, o_rec_valid, o_rec_data[31]}, 32'h2);
    @(posedge i_clk);
    i_ph_valid <= 1'b0;
    wr(ADR_CTRL, 32'h2);
    $display("marker test done");
  endtask
  task automatic t_trig();
    int n;
    wr(ADR_TRIG, 32'h4);
    wr(ADR_CTRL, 32'h400);
    for (int k = 0; k < 3; k++)
    begin
      n = 0;
      do
      begin
        @(negedge i_clk);
        n++;
      end
      while (o_trig !== 1'b1 && n < 30);
      if (k > 0) chk(n, 5);
    end
    @(posedge i_clk);
    wr(ADR_CTRL, 32'h0);
    $display("trigger test done");
  endtask
  task automatic t_gps();
    i_ecp_lab_model.send_str("$GPZDA,123456.00,07,08,2024,00,00*");
    rd(ADR_STATUS, 32'h4, 32'h4);
    i_ecp_lab_model.pulse(6);
    rd(ADR_TOD, 32'hC8B8, 32'h1FFFF);
    rd(ADR_DATE, 32'hFD078, 32'h1FFFFF);
    rd(ADR_STATUS, 32'h8, 32'h8);
    $display("time code test done");
  endtask
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    t_regs();
    t_meas();
    t_markers();
    t_trig();
    t_gps();
    conclude();
  end
  // The serial sentence dominates the run at about 29600 cycles.
  initial
  begin
    repeat (60000) @(posedge i_clk);
    n_errors++;
    conclude();
  end
endmodule
